// *** hdl/cpu_timer_control_bits.sv ***
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Interrupt enable low blocks the timer request.
// - Enable high and count reaching zero requests.
// - Free-run bit keeps counting at breakpoint.
// - Mode 00 halts after the next decrement.
// - Mode 01 halts once count reaches zero.
// - Soft stop still raises zero interrupt first.
// - Reload bit reads zero; writing zero ignored.
// - Reload loads counter and prescaler.
// - One halt bit selects counting or stopped.
// - Halt bit one stops, zero runs, resets zero.
// - Zero sets flag; write one clears it.
// - Counter reloads from period on next tick.
module cpu_timer_control_bits (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic debug_halt,
    output logic timer_request,
    output logic emu_halted,
    output logic irq
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0] period_reg;
    logic [15:0] divide_down_reg;
    logic zero_irq_enable_reg;
    logic free_run_reg;
    logic soft_stop_reg;
    logic halt_control_reg;
    logic zero_reached_flag_reg;
    logic [1:0] irq_status_reg;
    logic [1:0] irq_mask_reg;
    logic emu_hold_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pslverr_reg;
    logic debug_meta_reg;
    logic debug_sync_reg;

    logic [31:0] count_value;
    logic [15:0] prescale_count;
    logic tick;
    logic zero_event;
    logic run;
    logic emu_stop_now;
    logic halt_event;
    logic mapped;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic setup_phase;
    logic wr_access;
    logic wr_count;
    logic wr_period;
    logic wr_control;
    logic wr_prescale;
    logic wr_status;
    logic wr_mask;
    logic reload_cmd;

    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign wr_count = wr_access && (paddr == cpu_timer_pkg::COUNT_OFFSET);
    assign wr_period = wr_access && (paddr == cpu_timer_pkg::PERIOD_OFFSET);
    assign wr_control = wr_access && (paddr == cpu_timer_pkg::CONTROL_OFFSET);
    assign wr_prescale = wr_access && (paddr == cpu_timer_pkg::PRESCALE_OFFSET);
    assign wr_status = wr_access && (paddr == cpu_timer_pkg::IRQ_STATUS_OFFSET);
    assign wr_mask = wr_access && (paddr == cpu_timer_pkg::IRQ_MASK_OFFSET);

    // Only a written one acts; the bit itself is never stored
    assign reload_cmd = wr_control && pwdata[cpu_timer_pkg::RELOAD_BIT];

    always_comb begin
        mapped = 1'b1;
        unique case (paddr)
            cpu_timer_pkg::COUNT_OFFSET,
            cpu_timer_pkg::PERIOD_OFFSET,
            cpu_timer_pkg::CONTROL_OFFSET,
            cpu_timer_pkg::PRESCALE_OFFSET,
            cpu_timer_pkg::IRQ_STATUS_OFFSET,
            cpu_timer_pkg::IRQ_MASK_OFFSET: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Zero-wait slave: the answer is ready in the first access cycle
    assign pready = psel && penable;
    // Error shown only in access, so an idle bus never reports one
    assign pslverr = pready && pslverr_reg;
    assign prdata = prdata_reg;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] control_word;

    always_comb begin
        control_word = 32'h0000_0000;
        control_word[cpu_timer_pkg::FLAG_BIT] = zero_reached_flag_reg;
        control_word[cpu_timer_pkg::IRQ_ENABLE_BIT] = zero_irq_enable_reg;
        control_word[cpu_timer_pkg::FREE_RUN_BIT] = free_run_reg;
        control_word[cpu_timer_pkg::SOFT_STOP_BIT] = soft_stop_reg;
        control_word[cpu_timer_pkg::HALT_BIT] = halt_control_reg;
    end

    always_comb begin
        prdata_next = 32'h0000_0000;
        unique case (paddr)
            cpu_timer_pkg::COUNT_OFFSET: prdata_next = count_value;
            cpu_timer_pkg::PERIOD_OFFSET: prdata_next = period_reg;
            cpu_timer_pkg::CONTROL_OFFSET: prdata_next = control_word;
            cpu_timer_pkg::PRESCALE_OFFSET: begin
                prdata_next[cpu_timer_pkg::DIVIDE_LSB +: 16] = divide_down_reg;
                prdata_next[cpu_timer_pkg::PRESCALE_LSB +: 16] = prescale_count;
            end
            cpu_timer_pkg::IRQ_STATUS_OFFSET: prdata_next = {30'h0, irq_status_reg};
            cpu_timer_pkg::IRQ_MASK_OFFSET: prdata_next = {30'h0, irq_mask_reg};
            default: prdata_next = 32'h0000_0000;
        endcase
    end

    // Captured in setup so the data comes from a flip-flop in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : prdata_next;
            pslverr_reg <= !mapped;
        end
    end

    // ------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_reg <= cpu_timer_pkg::PERIOD_RESET;
        end else if (wr_period) begin
            period_reg <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divide_down_reg <= cpu_timer_pkg::DIVIDE_RESET;
        end else if (wr_prescale) begin
            divide_down_reg <= pwdata[cpu_timer_pkg::DIVIDE_LSB +: 16];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_irq_enable_reg <= 1'b0;
            free_run_reg <= 1'b0;
            soft_stop_reg <= 1'b0;
            halt_control_reg <= 1'b0;
        end else if (wr_control) begin
            zero_irq_enable_reg <= pwdata[cpu_timer_pkg::IRQ_ENABLE_BIT];
            free_run_reg <= pwdata[cpu_timer_pkg::FREE_RUN_BIT];
            soft_stop_reg <= pwdata[cpu_timer_pkg::SOFT_STOP_BIT];
            halt_control_reg <= pwdata[cpu_timer_pkg::HALT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= cpu_timer_pkg::IRQ_MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_reg <= pwdata[cpu_timer_pkg::IRQ_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------
    // Zero flag: a new zero beats a clear in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_reached_flag_reg <= 1'b0;
        end else if (zero_event) begin
            zero_reached_flag_reg <= 1'b1;
        end else if (wr_control && pwdata[cpu_timer_pkg::FLAG_BIT]) begin
            zero_reached_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Breakpoint input and emulation stop
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_meta_reg <= 1'b0;
            debug_sync_reg <= 1'b0;
        end else begin
            debug_meta_reg <= debug_halt;
            debug_sync_reg <= debug_meta_reg;
        end
    end

    cpu_timer_pkg::emu_mode_e emu_mode;

    assign emu_mode = cpu_timer_pkg::emu_mode_e'({free_run_reg, soft_stop_reg});

    always_comb begin
        emu_stop_now = 1'b0;
        unique case (emu_mode)
            cpu_timer_pkg::EMU_HARD_STOP: emu_stop_now = tick;
            cpu_timer_pkg::EMU_SOFT_STOP: emu_stop_now = zero_event;
            cpu_timer_pkg::EMU_FREE_RUN,
            cpu_timer_pkg::EMU_FREE_RUN_ALT: emu_stop_now = 1'b0;
        endcase
    end

    // Hold lasts until the synchronised breakpoint goes away or free run is set, so counting then resumes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emu_hold_reg <= 1'b0;
        end else if (!debug_sync_reg || free_run_reg) begin
            emu_hold_reg <= 1'b0;
        end else if (emu_stop_now) begin
            emu_hold_reg <= 1'b1;
        end
    end

    assign halt_event = debug_sync_reg && !emu_hold_reg && emu_stop_now;
    assign emu_halted = emu_hold_reg;
    assign run = !halt_control_reg && !emu_hold_reg;

    // ------------------------------------------------------------
    // Interrupt status, mask and request
    // ------------------------------------------------------------
    logic [1:0] irq_set;

    assign irq_set[cpu_timer_pkg::IRQ_ZERO_BIT] = zero_event && zero_irq_enable_reg;
    assign irq_set[cpu_timer_pkg::IRQ_HALT_BIT] = halt_event;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= 2'h0;
        end else if (wr_status) begin
            irq_status_reg <= (irq_status_reg & ~pwdata[1:0]) | irq_set;
        end else begin
            irq_status_reg <= irq_status_reg | irq_set;
        end
    end

    // Zero event also reaches here while halting in soft stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_request <= 1'b0;
        end else begin
            timer_request <= zero_event && zero_irq_enable_reg;
        end
    end

    // Level output: stays high until software clears or masks the bit
    assign irq = |(irq_status_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // Counting datapath
    // ------------------------------------------------------------
    tick_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .load(reload_cmd),
        .divide_down(divide_down_reg),
        .prescale_count(prescale_count),
        .tick(tick)
    );

    down_counter u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .load(reload_cmd),
        .period_value(period_reg),
        .write_en(wr_count),
        .write_data(pwdata),
        .count_value(count_value),
        .zero_event(zero_event)
    );

endmodule

`default_nettype wire

// *** hdl/cpu_timer_pkg.sv ***
package cpu_timer_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] COUNT_OFFSET = 8'h00;
    localparam logic [7:0] PERIOD_OFFSET = 8'h04;
    localparam logic [7:0] CONTROL_OFFSET = 8'h08;
    localparam logic [7:0] PRESCALE_OFFSET = 8'h0C;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h14;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int FLAG_BIT = 15;
    localparam int IRQ_ENABLE_BIT = 14;
    localparam int FREE_RUN_BIT = 11;
    localparam int SOFT_STOP_BIT = 10;
    localparam int RELOAD_BIT = 5;
    localparam int HALT_BIT = 4;
    localparam int CONTROL_WIDTH = 16;

    // Prescale register: divide-down low half, live count high half
    localparam int DIVIDE_LSB = 0;
    localparam int PRESCALE_LSB = 16;

    // Interrupt status / mask bits
    localparam int IRQ_ZERO_BIT = 0;
    localparam int IRQ_HALT_BIT = 1;
    localparam int IRQ_WIDTH = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] PERIOD_RESET = 32'h0000_FFFF;
    localparam logic [15:0] DIVIDE_RESET = 16'h0000;
    localparam logic [15:0] PRESCALE_RESET = 16'h0000;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h1;

    // Emulation modes as {free, soft}
    typedef enum logic [1:0] {
        EMU_HARD_STOP = 2'h0,
        EMU_SOFT_STOP = 2'h1,
        EMU_FREE_RUN = 2'h2,
        EMU_FREE_RUN_ALT = 2'h3
    } emu_mode_e;

endpackage

// *** hdl/down_counter.sv ***
`timescale 1ns/1ps
`default_nettype none

module down_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic load,
    input wire logic [31:0] period_value,
    input wire logic write_en,
    input wire logic [31:0] write_data,
    output logic [31:0] count_value,
    output logic zero_event
);

    // Decrement that lands on zero this cycle
    assign zero_event = tick && !load && !write_en && (count_value == 32'h0000_0001);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value <= cpu_timer_pkg::COUNT_RESET;
        end else if (load) begin
            count_value <= period_value;
        end else if (write_en) begin
            count_value <= write_data;
        end else if (tick) begin
            // Zero holds for one tick, reload comes with the next one
            if (count_value == 32'h0000_0000) begin
                count_value <= period_value;
            end else begin
                count_value <= count_value - 32'h0000_0001;
            end
        end
    end

endmodule

`default_nettype wire

// *** hdl/tick_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none

module tick_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] divide_down,
    output logic [15:0] prescale_count,
    output logic tick
);

    // Tick on the cycle the count sits at zero; period is divide_down + 1
    assign tick = run && !load && (prescale_count == 16'h0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_count <= cpu_timer_pkg::PRESCALE_RESET;
        end else if (load) begin
            prescale_count <= divide_down;
        end else if (run) begin
            if (prescale_count == 16'h0000) begin
                prescale_count <= divide_down;
            end else begin
                prescale_count <= prescale_count - 16'h0001;
            end
        end
    end

endmodule

`default_nettype wire

// *** sim/cpu_timer_control_bits_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module cpu_timer_control_bits_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic debug_halt,
    input wire logic timer_request,
    input wire logic emu_halted,
    input wire logic irq
);
    // ------------------------------------------------------------
    // Shadows of what software wrote
    // ------------------------------------------------------------
    logic [15:0] ctl_sh;
    logic mask_sh;
    logic [2:0] free_cnt;
    logic wr;
    logic unmapped;
    assign wr = psel && penable && pwrite;
    assign unmapped = (paddr > 8'h14) || (paddr[1:0] != 2'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_sh <= 16'h0000;
        end else if (wr && paddr == cpu_timer_pkg::CONTROL_OFFSET) begin
            ctl_sh <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_sh <= 1'b1;
        end else if (wr && paddr == cpu_timer_pkg::IRQ_MASK_OFFSET) begin
            mask_sh <= pwdata[0];
        end
    end

    // Saturates so the free-run check waits out the release latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            free_cnt <= 3'h0;
        end else if (!ctl_sh[11]) begin
            free_cnt <= 3'h0;
        end else if (free_cnt != 3'h7) begin
            free_cnt <= free_cnt + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_zero_wait: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    a_unmapped_err: assert property (pready && unmapped |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_no_err: assert property (pready && !unmapped |-> !pslverr)
        else $error("mapped access flagged as error");
    a_write_reads_zero: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
        else $error("read data not zero on write");
    a_control_read_bits: assert property (pready && !pwrite && paddr == 8'h08 |->
        (prdata & 32'hFFFF_33EF) == 32'h0 && (prdata[15:0] & 16'h4C10) == (ctl_sh & 16'h4C10))
        else $error("control read back wrong");
    a_no_request_off: assert property (!ctl_sh[14] && !$past(ctl_sh[14]) |-> !timer_request)
        else $error("request while disabled");
    a_request_pulse: assert property (timer_request |=> !timer_request)
        else $error("request longer than one cycle");
    a_request_sets_irq: assert property (timer_request && mask_sh |-> ##[0:1] irq)
        else $error("irq missing after request");
    a_free_no_halt: assert property (free_cnt == 3'h7 |-> !emu_halted)
        else $error("halted in free run");
    a_break_release: assert property (!debug_halt [*5] |=> !emu_halted)
        else $error("halt held without breakpoint");
    a_soft_stop_irq: assert property ($rose(emu_halted) && ctl_sh[10] && !ctl_sh[11] && ctl_sh[14]
        |-> timer_request || $past(timer_request))
        else $error("soft stop without request");

    c_request: cover property (timer_request);
    c_halt: cover property ($rose(emu_halted));
    c_error: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule

bind cpu_timer_control_bits cpu_timer_control_bits_checker i_cpu_timer_control_bits_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_halt(debug_halt), .timer_request(timer_request), .emu_halted(emu_halted),
    .irq(irq)
);

`default_nettype wire

// *** sim/test_cpu_timer_control_bits.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_cpu_timer_control_bits;
    typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} note_s;
    localparam logic [7:0] CNT = cpu_timer_pkg::COUNT_OFFSET;
    localparam logic [7:0] PER = cpu_timer_pkg::PERIOD_OFFSET;
    localparam logic [7:0] CTL = cpu_timer_pkg::CONTROL_OFFSET;
    localparam logic [7:0] PSC = cpu_timer_pkg::PRESCALE_OFFSET;
    localparam logic [7:0] IST = cpu_timer_pkg::IRQ_STATUS_OFFSET;
    localparam logic [7:0] MSK = cpu_timer_pkg::IRQ_MASK_OFFSET;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, debug_halt = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, per, div;
    logic pready, pslverr, timer_request, emu_halted, irq;
    note_s notes[$];
    note_s nt;
    int miscompares = 0, n_tests = 0, cyc = 0, n_req = 0, t_req = 0, t_prev = 0, i, base, t0;

    always #4 pclk = ~pclk;

    cpu_timer_control_bits i_cpu_timer_control_bits (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .debug_halt(debug_halt), .timer_request(timer_request), .emu_halted(emu_halted),
        .irq(irq)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Mask zero means only the error response is judged
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] m = 32'h0, input logic [31:0] e = 32'h0, input logic er = 1'b0);
        notes.push_back('{e, m, er});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Sampled after the wait, so a write just landed is already visible
    task automatic bit_is(ref logic seen, input logic exp);
        @(negedge pclk);
        check({31'h0, seen}, {31'h0, exp});
    endtask

    task automatic wait_halt();
        for (i = 0; i < 300 && emu_halted !== 1'b1; i++) @(negedge pclk);
    endtask

    // ------------------------------------------------------------
    // Watcher: results taken in arrival order
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
        if (psel && penable && pready) begin
            nt = notes.pop_front();
            check(prdata & nt.mask, nt.data);
            check({31'h0, pslverr}, {31'h0, nt.err});
        end
        if (timer_request === 1'b1) begin
            n_req++;
            t_prev = t_req;
            t_req = cyc;
        end
    end

    initial begin
        void'($urandom(37828));
        per = 32'h2 + ($urandom % 8);
        div = $urandom % 4;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, PER, 0, 32'hFFFF_FFFF, 32'h0000_FFFF);
        apb(0, CTL, 0, 32'hFFFF_FFFF, 32'h0);
        apb(0, MSK, 0, 32'hFFFF_FFFF, 32'h1);
        apb(0, 8'h18, 0, 32'hFFFF_FFFF, 32'h0, 1'b1);
        apb(1, 8'h1C, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b1);
        apb(1, PSC, div);
        apb(1, CTL, 32'h10);
        apb(1, CNT, 32'h5);
        apb(1, CTL, 32'h10);
        apb(0, CNT, 0, 32'hFFFF_FFFF, 32'h5);
        apb(1, PER, per);
        apb(1, CTL, 32'h30);
        apb(0, CNT, 0, 32'hFFFF_FFFF, per);
        apb(0, PSC, 0, 32'hFFFF_FFFF, {div[15:0], div[15:0]});
        apb(0, CTL, 0, 32'hFFFF_FFFF, 32'h10);
        // Running with the request disabled
        apb(1, CTL, 32'h20);
        repeat (100) @(posedge pclk);
        check(32'(n_req), 32'h0);
        apb(1, CTL, 32'h10);
        apb(0, CTL, 0, 32'hFFFF, 32'h8010);
        apb(1, CTL, 32'h8010);
        apb(0, CTL, 0, 32'hFFFF, 32'h0010);
        apb(0, IST, 0, 32'h1, 32'h0);
        // Enabled: spacing of requests follows period and divide-down
        apb(1, CTL, 32'h4020);
        repeat (3 * (per + 1) * (div + 1) + 10) @(posedge pclk);
        check(32'(t_req - t_prev), (per + 1) * (div + 1));
        apb(1, CTL, 32'h4010);
        apb(0, IST, 0, 32'h1, 32'h1);
        bit_is(irq, 1'b1);
        apb(1, MSK, 32'h0);
        bit_is(irq, 1'b0);
        apb(1, MSK, 32'h1);
        bit_is(irq, 1'b1);
        apb(1, IST, 32'h1);
        bit_is(irq, 1'b0);
        // Breakpoint in free run, then hard stop, then soft stop
        @(posedge pclk);
        debug_halt <= 1'b1;
        apb(1, CTL, 32'h4820);
        base = n_req;
        repeat (100) @(posedge pclk);
        bit_is(emu_halted, 1'b0);
        check(32'(n_req > base), 32'h1);
        // Free with soft set too: soft is ignored
        apb(1, CTL, 32'h4C00);
        repeat (40) @(posedge pclk);
        bit_is(emu_halted, 1'b0);
        t0 = cyc;
        apb(1, CTL, 32'h4000);
        wait_halt();
        bit_is(emu_halted, 1'b1);
        check(32'(cyc - t0 <= div + 9), 32'h1);
        base = n_req;
        repeat (60) @(posedge pclk);
        check(32'(n_req), 32'(base));
        apb(0, IST, 0, 32'h2, 32'h2);
        debug_halt <= 1'b0;
        repeat (10) @(posedge pclk);
        apb(1, CTL, 32'h4420);
        debug_halt <= 1'b1;
        wait_halt();
        bit_is(emu_halted, 1'b1);
        check(32'(cyc - t_req <= 2), 32'h1);
        apb(0, CNT, 0, 32'hFFFF_FFFF, 32'h0);
        // Second reset in mid-run
        debug_halt <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        bit_is(emu_halted, 1'b0);
        apb(0, CTL, 0, 32'hFFFF_FFFF, 32'h0);
        repeat (4) @(posedge pclk);
        summarize();
    end
endmodule

`default_nettype wire
